// *** src/isp_flash_eeprom_sequencer.sv ***
// program/erase/verify sequencer for flash, otp and data eeprom
//
// What this block does
// [RQ1] memory access only while the debug mode input is high
// [RQ2] flash unlock: AA to F555, 55 to FAAA, A5 to F555 in a row
// [RQ3] eeprom unlock: A5 then 5A written to the data register
// [RQ4] mode 81 plus control 02 clears the page buffer
// [RQ5] page buffer stores each loaded byte and advances its pointer
// [RQ6] page write: select buffer, load, write mode, address, timing
// [RQ7] control 0B starts page program or page erase
// [RQ8] status bit 7 reads 1 when the operation has finished
// [RQ9] page erase ignores buffer data, uses erase mode 91
// [RQ10] bulk erase 8B erases main array, plus otp with mode 8D
// [RQ11] mode 85 makes flash reads return otp data
// [RQ12] otp page write uses write mode A5
// [RQ13] otp page erase uses erase mode 95
// [RQ14] modes A3 and A7 give program-verify reads
// [RQ15] mode 93 gives erase-verify reads
// [RQ16] mode 89 makes flash reads return the page buffer
// [RQ17] eeprom page address direct from data space or from address regs
// [RQ18] eeprom buffer reset uses mode 41, buffer select mode 49
// [RQ19] eeprom page write uses mode 61 and start 0B
// [RQ20] eeprom page erase uses mode 51
// [RQ21] eeprom bulk erase started by control 4B
// [RQ22] eeprom modes 63 and 53 give verify reads
// [RQ23] mode 49 makes eeprom reads return the page buffer
// [RQ24] done flag clears at start and sets at stop
// [RQ25] 10-bit timer on clock/128 ends when equal to timing register
// [RQ26] flash page is 128 bytes, offset bits ignored
// [RQ27] eeprom page is 16 bytes, offset bits ignored
// [RQ28] start ignored unless that memory was unlocked in this debug session
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/100ps
module isp_flash_eeprom_sequencer
  import isp_seq_pkg::*;
#(
  parameter int FLASH_PAGE_BYTES = FLASH_PAGE,
  parameter int EE_PAGE_BYTES    = EE_PAGE,
  parameter int PRESCALE_DIV     = PRESCALE
) (
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_b_i,
  // debug state
  input  wire logic              debug_mode_i,
  // register port
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [7:0]        reg_rdata_o,
  // memory space port
  input  wire logic [MEM_AW-1:0] mem_addr_i,
  input  wire logic              mem_xdata_i,
  input  wire logic [7:0]        mem_wdata_i,
  input  wire logic              mem_wr_i,
  input  wire logic              mem_rd_i,
  output logic      [7:0]        mem_rdata_o,
  output logic                   mem_rvalid_o,
  // cell array
  output logic                   cell_rd_o,
  output logic      [MEM_AW-1:0] cell_addr_o,
  output cell_rsel_t             cell_rsel_o,
  input  wire logic [7:0]        cell_rdata_i,
  output cell_op_t               cell_op_o,
  output logic      [MEM_AW-1:0] cell_page_o,
  input  wire logic [6:0]        cell_pb_idx_i,
  output logic      [7:0]        cell_pb_data_o
);
  localparam int PBW = $clog2(FLASH_PAGE_BYTES);
  localparam int PSW = $clog2(PRESCALE_DIV);
  localparam logic [PBW-1:0]    EE_PTR_MASK = PBW'(EE_PAGE_BYTES - 1);
  localparam logic [MEM_AW-1:0] FL_OFS_MASK = MEM_AW'(FLASH_PAGE_BYTES - 1);
  localparam logic [MEM_AW-1:0] EE_OFS_MASK = MEM_AW'(EE_PAGE_BYTES - 1);
  localparam logic [PSW-1:0]    PRE_LAST    = PSW'(PRESCALE_DIV - 1);

  logic [7:0]         mode_r;
  logic [7:0]         time_r;
  logic [7:0]         data_r;
  logic [7:0]         addr_hi_r, addr_mid_r, addr_lo_r;
  logic               done_r;
  unlock_t            fl_st_r;
  logic               ee_half_r, ee_open_r;
  logic [7:0]         pb_mem [FLASH_PAGE_BYTES];
  logic [PBW-1:0]     pb_ptr_r, pb_ptr_nxt, pb_rd_idx;
  logic [MEM_AW-1:0]  ee_direct_r;
  logic               indirect_r;
  seq_t               seq_r;
  logic [PSW-1:0]     pre_r;
  logic [TIMER_W-1:0] cnt_r;
  logic               rd_p1_r, rd_pb_r, rd_cell_r;
  logic [7:0]         pb_q_r;
  logic               m_en, m_fl, m_ee, m_pgm, m_ers, m_vfy, m_pb;
  logic               fl_open, ctrl_wr, pb_reset_cmd, pb_sel, pb_load, pb_read;
  logic               page_fl, page_ee, bulk_fl, bulk_ee, start_ok, tick;
  logic [MEM_AW-1:0]  raw_page;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  // mode decode
  assign m_en    = mode_r[MB_EN];
  assign m_fl    = mode_r[MB_FLASH];
  assign m_ee    = mode_r[MB_EE];
  assign m_pgm   = mode_r[MB_PGM] & m_en;
  assign m_ers   = mode_r[MB_ERS] & m_en;
  assign m_vfy   = mode_r[MB_VFY] & m_en;
  assign m_pb    = mode_r[MB_PB] & m_en & ~mode_r[MB_PGM] & ~mode_r[MB_ERS];
  assign fl_open = (fl_st_r == UL_OPEN);
  assign ctrl_wr = reg_wr_i && (reg_addr_i == OFS_CTRL);

  // register writes
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_r     <= REG_RESET;
      time_r     <= REG_RESET;
      data_r     <= REG_RESET;
      addr_hi_r  <= REG_RESET;
      addr_mid_r <= REG_RESET;
      addr_lo_r  <= REG_RESET;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        OFS_MODE:     mode_r     <= reg_wdata_i;
        OFS_TIME:     time_r     <= reg_wdata_i;
        OFS_DATA:     data_r     <= reg_wdata_i;
        OFS_ADDR_HI:  addr_hi_r  <= reg_wdata_i;
        OFS_ADDR_MID: addr_mid_r <= reg_wdata_i;
        OFS_ADDR_LO:  addr_lo_r  <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // register reads, one cycle later; address regs are write-only
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= REG_RESET;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        OFS_MODE: reg_rdata_o <= mode_r;
        OFS_STAT: reg_rdata_o <= {done_r, 4'h0, m_pgm, m_ers, m_vfy}; // RQ8
        OFS_TIME: reg_rdata_o <= time_r;
        OFS_DATA: reg_rdata_o <= data_r;
        default:  reg_rdata_o <= REG_RESET;
      endcase
    end else begin
      reg_rdata_o <= REG_RESET;
    end
  end

  // flash unlock sequence on code-space writes
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fl_st_r <= UL_IDLE;
    end else if (!debug_mode_i) begin
      fl_st_r <= UL_IDLE; // RQ28
    end else if (mem_wr_i && !mem_xdata_i) begin
      unique case (fl_st_r) // RQ2
        UL_IDLE: fl_st_r <= (mem_wdata_i == FL_KEY1 && mem_addr_i == FL_ADDR1) ?
                            UL_KEY1 : UL_IDLE;
        UL_KEY1: fl_st_r <= (mem_wdata_i == FL_KEY2 && mem_addr_i == FL_ADDR2) ?
                            UL_KEY2 : UL_IDLE;
        UL_KEY2: fl_st_r <= (mem_wdata_i == FL_KEY3 && mem_addr_i == FL_ADDR1) ?
                            UL_OPEN : UL_IDLE;
        UL_OPEN: fl_st_r <= UL_OPEN;
      endcase
    end
  end

  // eeprom unlock sequence on data register writes
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ee_half_r <= 1'b0;
      ee_open_r <= 1'b0;
    end else if (!debug_mode_i) begin
      ee_half_r <= 1'b0; // RQ28
      ee_open_r <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == OFS_DATA && !ee_open_r) begin
      ee_open_r <= ee_half_r && (reg_wdata_i == EE_KEY2); // RQ3
      ee_half_r <= (reg_wdata_i == EE_KEY1);
    end
  end

  // page buffer control
  assign pb_reset_cmd = ctrl_wr && reg_wdata_i == CTRL_PB_RESET && m_en &&
                        (m_fl || m_ee) && seq_r == SEQ_IDLE; // RQ4 RQ18
  assign pb_sel  = m_pb && (m_fl || m_ee); // RQ18
  assign pb_load = debug_mode_i && mem_wr_i && pb_sel && (mem_xdata_i == m_ee) &&
                   seq_r == SEQ_IDLE;
  assign pb_ptr_nxt = m_ee ? ((pb_ptr_r + 1'b1) & EE_PTR_MASK) : (pb_ptr_r + 1'b1); // RQ5 RQ27

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pb_ptr_r <= '0;
    end else if (pb_reset_cmd) begin
      pb_ptr_r <= '0;
    end else if (pb_load) begin
      pb_ptr_r <= pb_ptr_nxt; // RQ5
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (pb_reset_cmd) begin
      for (int i = 0; i < FLASH_PAGE_BYTES; i++) begin
        pb_mem[i] <= REG_RESET; // RQ4
      end
    end else if (pb_load) begin
      pb_mem[pb_ptr_r] <= mem_wdata_i; // RQ5
    end
  end

  always_ff @(posedge ref_clk_i) begin
    cell_pb_data_o <= pb_mem[cell_pb_idx_i[PBW-1:0]];
  end

  // eeprom page address: direct capture or indirect registers
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ee_direct_r <= '0;
      indirect_r  <= 1'b0;
    end else begin
      if (pb_load && mem_xdata_i) begin
        ee_direct_r <= mem_addr_i; // RQ17
      end
      if (reg_wr_i && (reg_addr_i == OFS_ADDR_LO || reg_addr_i == OFS_ADDR_MID ||
                       reg_addr_i == OFS_ADDR_HI)) begin
        indirect_r <= 1'b1; // RQ17
      end else if (pb_reset_cmd) begin
        indirect_r <= 1'b0;
      end
    end
  end

  // start decode
  assign page_fl = m_fl && fl_open && ((m_pgm && !m_ers) || (m_ers && !m_pgm)); // RQ6 RQ9
  assign page_ee = m_ee && ee_open_r && ((m_pgm && !m_ers) || (m_ers && !m_pgm)); // RQ19 RQ20
  assign bulk_fl = m_fl && fl_open && (m_ers || mode_r == MODE_BULK_OTP); // RQ10
  assign bulk_ee = m_ee && ee_open_r && m_ers; // RQ21
  assign start_ok = ctrl_wr && debug_mode_i && seq_r == SEQ_IDLE && !m_vfy &&
                    ((reg_wdata_i == CTRL_START && (page_fl || page_ee)) || // RQ7 RQ28
                     (reg_wdata_i == CTRL_BULK_FL && bulk_fl) ||
                     (reg_wdata_i == CTRL_BULK_EE && bulk_ee));
  assign raw_page = (m_ee && !indirect_r) ? ee_direct_r :
                    {addr_hi_r, addr_mid_r, addr_lo_r};
  assign tick = (pre_r == PRE_LAST);

  // program/erase sequencer and timer
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seq_r       <= SEQ_IDLE;
      done_r      <= 1'b1;
      pre_r       <= '0;
      cnt_r       <= '0;
      cell_op_o   <= '0;
      cell_page_o <= '0;
    end else begin
      unique case (seq_r)
        SEQ_IDLE: begin
          if (start_ok) begin
            seq_r            <= SEQ_RUN;
            done_r           <= 1'b0; // RQ24
            pre_r            <= '0;
            cnt_r            <= '0; // RQ25
            cell_op_o.bulk   <= (reg_wdata_i != CTRL_START); // RQ10 RQ21
            cell_op_o.prog   <= (reg_wdata_i == CTRL_START) && m_pgm; // RQ7
            cell_op_o.erase  <= (reg_wdata_i != CTRL_START) || m_ers; // RQ9
            cell_op_o.eeprom <= m_ee;
            cell_op_o.otp    <= m_fl && mode_r[MB_OTP]; // RQ10 RQ12 RQ13
            cell_page_o      <= m_ee ? (raw_page & ~EE_OFS_MASK) : // RQ27
                                       (raw_page & ~FL_OFS_MASK); // RQ26
          end
        end
        SEQ_RUN: begin
          pre_r <= tick ? '0 : pre_r + 1'b1; // RQ25
          if (tick) begin
            if (cnt_r == TIMER_W'(time_r)) begin
              seq_r     <= SEQ_IDLE;
              done_r    <= 1'b1; // RQ24
              cell_op_o <= '0;
            end else begin
              cnt_r <= cnt_r + 1'b1; // RQ25
            end
          end
        end
      endcase
    end
  end

  // memory reads, data two cycles after the strobe
  assign pb_read   = debug_mode_i && pb_sel && (mem_xdata_i == m_ee); // RQ16 RQ23
  assign pb_rd_idx = m_ee ? (mem_addr_i[PBW-1:0] & EE_PTR_MASK) : mem_addr_i[PBW-1:0];

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_p1_r      <= 1'b0;
      rd_pb_r      <= 1'b0;
      rd_cell_r    <= 1'b0;
      pb_q_r       <= REG_RESET;
      cell_rd_o    <= 1'b0;
      cell_addr_o  <= '0;
      cell_rsel_o  <= '0;
      mem_rvalid_o <= 1'b0;
      mem_rdata_o  <= REG_RESET;
    end else begin
      rd_p1_r   <= mem_rd_i;
      rd_pb_r   <= mem_rd_i && pb_read;
      rd_cell_r <= mem_rd_i && debug_mode_i && !pb_read; // RQ1
      cell_rd_o <= mem_rd_i && debug_mode_i && !pb_read; // RQ1
      if (mem_rd_i) begin
        pb_q_r              <= pb_mem[pb_rd_idx]; // RQ16 RQ23
        cell_addr_o         <= mem_addr_i;
        cell_rsel_o.eeprom  <= mem_xdata_i;
        cell_rsel_o.otp     <= !mem_xdata_i && m_fl && mode_r[MB_OTP] && m_en; // RQ11
        cell_rsel_o.vfy_pgm <= m_vfy && m_pgm; // RQ14 RQ22
        cell_rsel_o.vfy_ers <= m_vfy && m_ers; // RQ15 RQ22
      end
      mem_rvalid_o <= rd_p1_r;
      mem_rdata_o  <= rd_pb_r ? pb_q_r : (rd_cell_r ? cell_rdata_i : REG_RESET);
    end
  end

  // checks
  a_flash_unlock_seq: assert property ( // RQ2
    $rose(fl_open) |-> $past(mem_wr_i && mem_wdata_i == FL_KEY3 && mem_addr_i == FL_ADDR1))
    else $error("flash unlock without final key write");
  a_ee_unlock_seq: assert property ( // RQ3
    $rose(ee_open_r) |-> $past(reg_wr_i && reg_addr_i == OFS_DATA &&
                               reg_wdata_i == EE_KEY2) && $past(ee_half_r))
    else $error("eeprom unlock out of order");
  a_pb_reset_clear: assert property ( // RQ4
    pb_reset_cmd |=> pb_ptr_r == '0 && pb_mem[0] == REG_RESET)
    else $error("page buffer not cleared");
  a_pb_load_store: assert property ( // RQ5
    pb_load |=> pb_mem[$past(pb_ptr_r)] == $past(mem_wdata_i) && pb_ptr_r != $past(pb_ptr_r))
    else $error("page buffer load lost or pointer stuck");
  a_start_busy: assert property ( // RQ24
    start_ok |=> !done_r && (cell_op_o.prog || cell_op_o.erase) ##1 !done_r)
    else $error("busy not shown after start");
  a_locked_start: assert property ( // RQ28
    $fell(done_r) |-> $past(fl_open || ee_open_r) && $past(debug_mode_i))
    else $error("operation started while locked");
  a_timer_end: assert property ( // RQ25
    $rose(done_r) |-> $past(cnt_r == TIMER_W'(time_r)) && $past(tick))
    else $error("operation ended off the timer compare");
  a_min_run: assert property ( // RQ25
    start_ok |=> !done_r [*8])
    else $error("operation shorter than one prescaler period");
  a_flash_page_align: assert property ( // RQ26
    cell_op_o.prog && !cell_op_o.eeprom |-> (cell_page_o & FL_OFS_MASK) == '0)
    else $error("flash page address not aligned");
  a_debug_gate: assert property ( // RQ1
    mem_rd_i && !debug_mode_i |=> !cell_rd_o ##1 mem_rvalid_o && mem_rdata_o == REG_RESET)
    else $error("read served outside debug mode");
  a_otp_select: assert property ( // RQ11
    mem_rd_i && debug_mode_i && !mem_xdata_i && mode_r == MODE_OTP_READ
    |=> cell_rd_o && cell_rsel_o.otp)
    else $error("otp read not selected");
  a_pvfy_select: assert property ( // RQ14
    mem_rd_i && debug_mode_i && !mem_xdata_i && mode_r == MODE_FL_PVFY
    |=> cell_rsel_o.vfy_pgm && !cell_rsel_o.vfy_ers)
    else $error("program verify not selected");
  c_flash_unlock: cover property ($rose(fl_open));
  c_page_prog:    cover property (start_ok && reg_wdata_i == CTRL_START && m_pgm);
  c_bulk_ee:      cover property (start_ok && reg_wdata_i == CTRL_BULK_EE);
  c_pb_readback:  cover property (rd_pb_r ##1 mem_rvalid_o);
endmodule

// *** src/isp_seq_pkg.sv ***
// constants and types for the isp flash/eeprom sequencer
package isp_seq_pkg;
  localparam logic [7:0]  OFS_MODE      = 8'hEA;
  localparam logic [7:0]  OFS_CTRL      = 8'hEB;
  localparam logic [7:0]  OFS_STAT      = 8'hEC;
  localparam logic [7:0]  OFS_TIME      = 8'hED;
  localparam logic [7:0]  OFS_ADDR_LO   = 8'hF2;
  localparam logic [7:0]  OFS_ADDR_MID  = 8'hF3;
  localparam logic [7:0]  OFS_ADDR_HI   = 8'hF4;
  localparam logic [7:0]  OFS_DATA      = 8'hF5;
  localparam int          MB_FLASH      = 7;
  localparam int          MB_EE         = 6;
  localparam int          MB_PGM        = 5;
  localparam int          MB_ERS        = 4;
  localparam int          MB_PB         = 3;
  localparam int          MB_OTP        = 2;
  localparam int          MB_VFY        = 1;
  localparam int          MB_EN         = 0;
  localparam logic [7:0]  MODE_BULK_OTP = 8'h8D;
  localparam logic [7:0]  MODE_OTP_READ = 8'h85;
  localparam logic [7:0]  MODE_FL_PVFY  = 8'hA3;
  localparam logic [7:0]  CTRL_PB_RESET = 8'h02;
  localparam logic [7:0]  CTRL_START    = 8'h0B;
  localparam logic [7:0]  CTRL_BULK_FL  = 8'h8B;
  localparam logic [7:0]  CTRL_BULK_EE  = 8'h4B;
  localparam logic [7:0]  FL_KEY1       = 8'hAA;
  localparam logic [7:0]  FL_KEY2       = 8'h55;
  localparam logic [7:0]  FL_KEY3       = 8'hA5;
  localparam logic [23:0] FL_ADDR1      = 24'h00F555;
  localparam logic [23:0] FL_ADDR2      = 24'h00FAAA;
  localparam logic [7:0]  EE_KEY1       = 8'hA5;
  localparam logic [7:0]  EE_KEY2       = 8'h5A;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam int          STAT_DONE     = 7;
  localparam int          PRESCALE      = 128;
  localparam int          TIMER_W       = 10;
  localparam int          FLASH_PAGE    = 128;
  localparam int          EE_PAGE       = 16;
  localparam int          MEM_AW        = 24;

  typedef struct packed {
    logic prog;
    logic erase;
    logic bulk;
    logic eeprom;
    logic otp;
  } cell_op_t;

  typedef struct packed {
    logic eeprom;
    logic otp;
    logic vfy_pgm;
    logic vfy_ers;
  } cell_rsel_t;

  typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_KEY2, UL_OPEN} unlock_t;
  typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_t;
endpackage

// *** verification/cell_array_model.sv ***
// cell array stand-in that answers array reads from the sequencer
`timescale 1ns/100ps
module cell_array_model
  import isp_seq_pkg::*;
(
  // clock
  input  wire logic              ref_clk_i,
  // array read side
  input  wire logic              cell_rd_i,
  input  wire logic [MEM_AW-1:0] cell_addr_i,
  input  wire cell_rsel_t        cell_rsel_i,
  output logic      [7:0]        cell_rdata_o
);
  logic [7:0] last_r = 8'h3C;

  always_ff @(posedge ref_clk_i) begin
    last_r <= cell_rdata_o;
  end

  // data only while read, otherwise a pattern that flips every cycle
  always_comb begin
    if (cell_rd_i)
      cell_rdata_o = cell_addr_i[7:0] ^ {4'h0, cell_rsel_i};
    else
      cell_rdata_o = ~last_r;
  end
endmodule

// *** verification/tb_isp_flash_eeprom_sequencer.sv ***
// self-checking bench for the isp flash/eeprom sequencer
`timescale 1ns/100ps
module tb_isp_flash_eeprom_sequencer
  import isp_seq_pkg::*;
;
  localparam int PD    = 8;
  localparam int LIMIT = 20000;
  logic              clk;
  logic              rst_b = 1'b0;
  logic              dbg = 1'b0;
  logic [7:0]        ra = 8'h00;
  logic [7:0]        rwd = 8'h00;
  logic              rwr = 1'b0;
  logic              rrd = 1'b0;
  logic [7:0]        rdat;
  logic [MEM_AW-1:0] ma = '0;
  logic              mx = 1'b0;
  logic [7:0]        mwd = 8'h00;
  logic              mwr = 1'b0;
  logic              mrd_s = 1'b0;
  logic [7:0]        mdat;
  logic              mval;
  logic              crd;
  logic [MEM_AW-1:0] caddr;
  cell_rsel_t        crsel;
  logic [7:0]        cdat;
  cell_op_t          cop;
  logic [MEM_AW-1:0] cpage;
  logic [6:0]        pidx = 7'h00;
  logic [7:0]        pdat;
  int                compares = 0;
  int                err_total = 0;
  int                cyc = 0;
  logic [7:0]        pb_exp [4] = '{8'h11, 8'h22, 8'h33, 8'h00};

  isp_flash_eeprom_sequencer #(.PRESCALE_DIV(PD)) i_isp_flash_eeprom_sequencer (
    .ref_clk_i(clk), .rst_b_i(rst_b), .debug_mode_i(dbg),
    .reg_addr_i(ra), .reg_wdata_i(rwd), .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(rdat),
    .mem_addr_i(ma), .mem_xdata_i(mx), .mem_wdata_i(mwd), .mem_wr_i(mwr), .mem_rd_i(mrd_s),
    .mem_rdata_o(mdat), .mem_rvalid_o(mval), .cell_rd_o(crd), .cell_addr_o(caddr),
    .cell_rsel_o(crsel), .cell_rdata_i(cdat), .cell_op_o(cop), .cell_page_o(cpage),
    .cell_pb_idx_i(pidx), .cell_pb_data_o(pdat)
  );

  cell_array_model i_cell_array_model (
    .ref_clk_i(clk), .cell_rd_i(crd), .cell_addr_i(caddr), .cell_rsel_i(crsel),
    .cell_rdata_o(cdat)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ra <= a;
    rwd <= d;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    ra <= a;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    #1;
    chk(rdat, e);
    @(posedge clk);
  endtask

  task automatic mwrite(input logic x, input logic [23:0] a, input logic [7:0] d);
    mx <= x;
    ma <= a;
    mwd <= d;
    mwr <= 1'b1;
    @(posedge clk);
    mwr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic mread(input logic x, input logic [23:0] a, input logic [7:0] e,
                       input cell_rsel_t rs, input logic arr);
    mx <= x;
    ma <= a;
    mrd_s <= 1'b1;
    @(posedge clk);
    mrd_s <= 1'b0;
    #1;
    chk(crd, arr);
    if (arr)
      chk(crsel, rs);
    @(posedge clk);
    #1;
    chk({mval, mdat}, {1'b1, e});
    @(posedge clk);
  endtask

  task automatic vread(input logic [7:0] m, input logic x, input cell_rsel_t rs);
    wr(OFS_MODE, m);
    mread(x, 24'h000021, 8'h21 ^ {4'h0, rs}, rs, 1'b1);
  endtask

  task automatic run_op(input logic [7:0] m, input logic [7:0] c, input logic [7:0] t,
                        input cell_op_t op, input logic [23:0] pg, input logic ind);
    int n;
    logic [7:0] sb;
    n = 0;
    sb = {5'h00, m[MB_PGM], m[MB_ERS], m[MB_VFY]} & {8{m[MB_EN]}};
    wr(OFS_MODE, m[MB_EE] ? 8'h41 : 8'h81);
    wr(OFS_CTRL, CTRL_PB_RESET);
    wr(OFS_MODE, m[MB_EE] ? 8'h49 : 8'h89);
    mwrite(m[MB_EE], 24'h000345, 8'h00);
    wr(OFS_MODE, m);
    if (ind) begin
      wr(OFS_ADDR_HI, 8'h00);
      wr(OFS_ADDR_MID, 8'h12);
      wr(OFS_ADDR_LO, 8'hB4);
    end
    wr(OFS_TIME, t);
    wr(OFS_CTRL, c);
    rd(OFS_STAT, sb);
    #1;
    chk(cop, op);
    if (!op.bulk)
      chk(cpage, pg);
    while (cop !== 5'h00 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n, (int'(t) + 1) * PD - 3);
    @(posedge clk);
    rd(OFS_STAT, sb | 8'h80);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(OFS_STAT, 8'h80);
    rd(OFS_MODE, 8'h00);
    rd(OFS_ADDR_LO, 8'h00);
    rd(8'h10, 8'h00);
    mread(1'b0, 24'h000010, 8'h00, 4'h0, 1'b0);
    dbg <= 1'b1;
    @(posedge clk);
    mwrite(1'b0, FL_ADDR1, FL_KEY1);
    mwrite(1'b0, FL_ADDR2, FL_KEY2);
    mwrite(1'b0, FL_ADDR1, 8'hA4);
    wr(OFS_MODE, 8'hA1);
    wr(OFS_TIME, 8'h00);
    wr(OFS_CTRL, CTRL_START);
    rd(OFS_STAT, 8'h84);
    mwrite(1'b0, FL_ADDR1, FL_KEY1);
    mwrite(1'b0, FL_ADDR2, FL_KEY2);
    mwrite(1'b0, FL_ADDR1, FL_KEY3);
    wr(OFS_MODE, 8'h81);
    wr(OFS_CTRL, CTRL_PB_RESET);
    wr(OFS_MODE, 8'h89);
    for (int i = 0; i < 3; i++)
      mwrite(1'b0, 24'h000040, pb_exp[i]);
    for (int i = 0; i < 4; i++) begin
      pidx <= 7'(i);
      @(posedge clk);
      #1;
      chk(pdat, pb_exp[i]);
      @(posedge clk);
    end
    mread(1'b0, 24'h000001, 8'h22, 4'h0, 1'b0);
    run_op(8'hA1, CTRL_START, 8'h01, 5'h10, 24'h001280, 1'b1);
    run_op(8'h91, CTRL_START, 8'h00, 5'h08, 24'h001280, 1'b1);
    run_op(8'hA5, CTRL_START, 8'h02, 5'h11, 24'h001280, 1'b1);
    run_op(8'h95, CTRL_START, 8'h00, 5'h09, 24'h001280, 1'b1);
    run_op(8'h91, CTRL_BULK_FL, 8'h01, 5'h0C, 24'h0, 1'b0);
    run_op(MODE_BULK_OTP, CTRL_BULK_FL, 8'h00, 5'h0D, 24'h0, 1'b0);
    vread(MODE_OTP_READ, 1'b0, 4'b0100);
    vread(MODE_FL_PVFY, 1'b0, 4'b0010);
    vread(8'hA7, 1'b0, 4'b0110);
    vread(8'h93, 1'b0, 4'b0001);
    wr(OFS_MODE, 8'h61);
    wr(OFS_CTRL, CTRL_START);
    rd(OFS_STAT, 8'h84);
    wr(OFS_DATA, EE_KEY1);
    wr(OFS_DATA, EE_KEY2);
    run_op(8'h61, CTRL_START, 8'h01, 5'h12, 24'h0012B0, 1'b1);
    run_op(8'h51, CTRL_START, 8'h00, 5'h0A, 24'h000340, 1'b0);
    run_op(8'h51, CTRL_BULK_EE, 8'h00, 5'h0E, 24'h0, 1'b0);
    vread(8'h63, 1'b1, 4'b1010);
    vread(8'h53, 1'b1, 4'b1001);
    wr(OFS_MODE, 8'h41);
    wr(OFS_CTRL, CTRL_PB_RESET);
    wr(OFS_MODE, 8'h49);
    mwrite(1'b1, 24'h000345, 8'h5C);
    mread(1'b1, 24'h000000, 8'h5C, 4'h0, 1'b0);
    dbg <= 1'b0;
    @(posedge clk);
    dbg <= 1'b1;
    @(posedge clk);
    wr(OFS_MODE, 8'hA1);
    wr(OFS_CTRL, CTRL_START);
    rd(OFS_STAT, 8'h84);
    report_and_stop();
  end
endmodule
